// File: sam_decode.sv
`timescale 1ns/1ps
`default_nettype none
module sam_decode
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Endian strap
  input wire logic endian_strap_i,
  // Core access request
  input wire logic req_valid_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [1:0] req_size_i,
  input wire logic req_write_i,
  input wire logic req_fetch_i,
  input wire logic req_priv_i,
  input wire logic [31:0] req_wdata_i,
  output logic req_ready_o,
  // Region attributes
  output logic [1:0] attr_mem_type_o,
  output logic [1:0] attr_cache_o,
  output logic attr_shareable_o,
  output logic attr_execute_never_o,
  output logic private_peripheral_region_o,
  output logic vendor_system_region_o,
  output logic default_map_used_o,
  // Protection unit
  input wire logic protection_unit_enable_i,
  input wire logic privileged_default_map_enable_i,
  input wire logic protection_unit_hit_i,
  // Fault
  output logic hard_fault_exception_o,
  // Fabric side
  output logic mem_req_o,
  output logic [31:0] mem_addr_o,
  output logic [1:0] mem_size_o,
  output logic mem_write_o,
  output logic [31:0] mem_wdata_o,
  output logic mem_strongly_ordered_o,
  input wire logic mem_done_i,
  input wire logic [31:0] mem_rdata_i,
  // Read return
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  // Status
  output logic endian_select_bit_o,
  output logic [31:0] vector_table_base_o,
  // Barriers
  input wire logic data_sync_barrier_i,
  input wire logic instr_sync_barrier_i,
  output logic dsb_done_o,
  output logic isb_done_o,
  // Tick timer pend
  input wire logic tick_timer_enable_i,
  input wire logic tick_event_i,
  input wire logic tick_pend_clear_i,
  output logic tick_pend_set_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sam_pkg::sam_state_t state;
  sam_pkg::sam_state_t next_state;
  logic [2:0] part;
  logic is_ppb;
  logic misaligned;
  logic pu_deny;
  logic fault;
  logic accept;
  logic swap_wr;
  logic [31:0] wdata_sw;
  logic [31:0] rdata_sw;
  logic held_ppb;
  logic held_swap;
  logic dsb_wait;
  logic isb_wait;

  assign part = req_addr_i[sam_pkg::PART_HI:sam_pkg::PART_LO]; // R1
  assign is_ppb = (part == sam_pkg::PART_SYSTEM) &&
    (req_addr_i[sam_pkg::SUB_HI:sam_pkg::SUB_LO] == sam_pkg::SUB_PRIVATE);

  // ----------------------------------------------------------------
  // Default map decode
  // ----------------------------------------------------------------
  // Purely combinational so the core sees attributes in its request cycle.
  always_comb // R25
  begin
    attr_mem_type_o = sam_pkg::MEM_DEVICE;
    attr_cache_o = sam_pkg::CACHE_NONE;
    attr_shareable_o = 1'b0;
    attr_execute_never_o = 1'b1;
    case (part)
      sam_pkg::PART_CODE: // R2
      begin
        attr_mem_type_o = sam_pkg::MEM_NORMAL;
        attr_cache_o = sam_pkg::CACHE_WT;
        attr_execute_never_o = 1'b0;
      end
      sam_pkg::PART_SRAM: // R3
      begin
        attr_mem_type_o = sam_pkg::MEM_NORMAL;
        attr_cache_o = sam_pkg::CACHE_WRITE_BACK_ALLOCATE_POLICY;
        attr_execute_never_o = 1'b0;
      end
      sam_pkg::PART_PERIPH: // R4
      begin
        attr_mem_type_o = sam_pkg::MEM_DEVICE;
      end
      sam_pkg::PART_RAM_WRITE_BACK_ALLOCATE_POLICY: // R5
      begin
        attr_mem_type_o = sam_pkg::MEM_NORMAL;
        attr_cache_o = sam_pkg::CACHE_WRITE_BACK_ALLOCATE_POLICY; // R12
        attr_execute_never_o = 1'b0;
      end
      sam_pkg::PART_RAM_WT: // R6
      begin
        attr_mem_type_o = sam_pkg::MEM_NORMAL;
        attr_cache_o = sam_pkg::CACHE_WT;
        attr_execute_never_o = 1'b0;
      end
      sam_pkg::PART_DEV_SHARED: // R7
      begin
        attr_shareable_o = 1'b1;
      end
      sam_pkg::PART_DEV_PRIVATE: // R7
      begin
        attr_shareable_o = 1'b0;
      end
      sam_pkg::PART_SYSTEM: // R8
      begin
        if (is_ppb) // R9
        begin
          attr_mem_type_o = sam_pkg::MEM_STRONG;
          attr_shareable_o = 1'b1; // R13
        end
      end
      default:
      begin
        attr_execute_never_o = 1'b1;
      end
    endcase
  end

  assign private_peripheral_region_o = is_ppb; // R9
  assign vendor_system_region_o = (part == sam_pkg::PART_SYSTEM) && !is_ppb;
  assign vector_table_base_o = sam_pkg::VECTOR_BASE; // R14

  // ----------------------------------------------------------------
  // Fault checks
  // ----------------------------------------------------------------
  always_comb // R23
  begin
    misaligned = 1'b1;
    if (req_size_i == sam_pkg::SIZE_BYTE)
    begin
      misaligned = 1'b0;
    end
    else if (req_size_i == sam_pkg::SIZE_HALF)
    begin
      misaligned = req_addr_i[0];
    end
    else if (req_size_i == sam_pkg::SIZE_WORD)
    begin
      misaligned = (req_addr_i[1:0] != sam_pkg::LOW2_ZERO);
    end
  end

  // A protection-unit miss only falls back on the default map for
  // privileged code that has asked for it.
  assign default_map_used_o = !protection_unit_enable_i ||
    (!protection_unit_hit_i && req_priv_i &&
     privileged_default_map_enable_i); // R22
  assign pu_deny = protection_unit_enable_i && !protection_unit_hit_i &&
    !(req_priv_i && privileged_default_map_enable_i); // R22

  assign fault = (req_fetch_i && attr_execute_never_o) || // R11
    (!req_fetch_i && misaligned) || // R23
    (is_ppb && !req_priv_i) || pu_deny;

  assign req_ready_o = (state == sam_pkg::ST_IDLE);
  assign accept = req_valid_i && req_ready_o;

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      hard_fault_exception_o <= 1'b0;
    end
    else
    begin
      hard_fault_exception_o <= accept && fault; // R11
    end
  end

  // ----------------------------------------------------------------
  // Endianness
  // ----------------------------------------------------------------
  // Sampled while reset is held so software sees a constant afterwards.
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      endian_select_bit_o <= endian_strap_i; // R15 R18
    end
  end

  // Fetches and private peripheral traffic bypass the byte swap.
  assign swap_wr = endian_select_bit_o && !req_fetch_i && !is_ppb; // R16 R17

  sam_byte_rev u_wr_rev
  (
    .swap_i(swap_wr),
    .size_i(req_size_i),
    .data_i(req_wdata_i),
    .data_o(wdata_sw)
  );

  sam_byte_rev u_rd_rev
  (
    .swap_i(held_swap),
    .size_i(mem_size_o),
    .data_i(mem_rdata_i),
    .data_o(rdata_sw)
  );

  // ----------------------------------------------------------------
  // Fabric sequencing
  // ----------------------------------------------------------------
  // One access outstanding at a time, which keeps strongly-ordered
  // private peripheral traffic unbuffered at the cost of throughput.
  always_comb
  begin
    next_state = state;
    case (state)
      sam_pkg::ST_IDLE:
      begin
        if (accept && !fault)
        begin
          next_state = sam_pkg::ST_ISSUE;
        end
      end
      sam_pkg::ST_ISSUE:
      begin
        next_state = sam_pkg::ST_WAIT;
      end
      sam_pkg::ST_WAIT:
      begin
        if (mem_done_i)
        begin
          next_state = sam_pkg::ST_IDLE;
        end
      end
      default:
      begin
        next_state = sam_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      state <= sam_pkg::ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign mem_req_o = (state == sam_pkg::ST_ISSUE);

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      mem_addr_o <= 32'h0000_0000;
      mem_size_o <= sam_pkg::SIZE_BYTE;
      mem_write_o <= 1'b0;
      mem_wdata_o <= 32'h0000_0000;
      mem_strongly_ordered_o <= 1'b0;
      held_ppb <= 1'b0;
      held_swap <= 1'b0;
    end
    else if (accept && !fault)
    begin
      mem_addr_o <= req_addr_i;
      mem_size_o <= req_size_i;
      mem_write_o <= req_write_i;
      mem_wdata_o <= wdata_sw; // R24
      mem_strongly_ordered_o <= is_ppb; // R26
      held_ppb <= is_ppb;
      held_swap <= swap_wr;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      rdata_o <= 32'h0000_0000;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= (state == sam_pkg::ST_WAIT) && mem_done_i && !mem_write_o;
      if ((state == sam_pkg::ST_WAIT) && mem_done_i && !mem_write_o)
      begin
        rdata_o <= rdata_sw; // R24
      end
    end
  end

  // ----------------------------------------------------------------
  // Barriers
  // ----------------------------------------------------------------
  assign dsb_done_o = dsb_wait &&
    !((state != sam_pkg::ST_IDLE) && held_ppb); // R19
  assign isb_done_o = isb_wait && (state == sam_pkg::ST_IDLE); // R20

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      dsb_wait <= 1'b0;
      isb_wait <= 1'b0;
    end
    else
    begin
      dsb_wait <= data_sync_barrier_i || (dsb_wait && !dsb_done_o);
      isb_wait <= instr_sync_barrier_i || (isb_wait && !isb_done_o);
    end
  end

  // ----------------------------------------------------------------
  // Tick pend status
  // ----------------------------------------------------------------
  // A tick landing in the clear cycle still pends; it can only come
  // while the timer is enabled, so a disable first stops it for good.
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      tick_pend_set_o <= 1'b0;
    end
    else if (tick_event_i && tick_timer_enable_i)
    begin
      tick_pend_set_o <= 1'b1; // R21
    end
    else if (tick_pend_clear_i)
    begin
      tick_pend_set_o <= 1'b0; // R21
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  fetch_xn_fault_a: assert property ( // R11
    @(posedge clk_sys_i) disable iff (srst_i)
    accept && req_fetch_i && attr_execute_never_o |=>
      hard_fault_exception_o ##1 !mem_req_o)
    else $error("execute-never fetch did not fault");

  align_fault_a: assert property ( // R23
    @(posedge clk_sys_i) disable iff (srst_i)
    accept && !req_fetch_i && req_size_i == sam_pkg::SIZE_WORD &&
      req_addr_i[0] |=> hard_fault_exception_o && !mem_req_o)
    else $error("misaligned word access did not fault");

  strong_share_a: assert property ( // R13
    @(posedge clk_sys_i) disable iff (srst_i)
    attr_mem_type_o == sam_pkg::MEM_STRONG |-> attr_shareable_o &&
      private_peripheral_region_o)
    else $error("strongly-ordered region not shareable");

  code_region_a: assert property ( // R2
    @(posedge clk_sys_i) disable iff (srst_i)
    part == sam_pkg::PART_CODE |->
      attr_cache_o == sam_pkg::CACHE_WT && !attr_execute_never_o)
    else $error("code region attributes wrong");

  device_xn_a: assert property ( // R7
    @(posedge clk_sys_i) disable iff (srst_i)
    attr_mem_type_o == sam_pkg::MEM_DEVICE |->
      attr_execute_never_o && attr_cache_o == sam_pkg::CACHE_NONE)
    else $error("device region executable or cached");

  ppb_little_a: assert property ( // R17
    @(posedge clk_sys_i) disable iff (srst_i)
    accept && !fault && is_ppb |=> !held_swap && mem_strongly_ordered_o)
    else $error("private peripheral access swapped");

  endian_hold_a: assert property ( // R15
    @(posedge clk_sys_i) disable iff (srst_i)
    !$past(srst_i) |-> $stable(endian_select_bit_o))
    else $error("endian select changed outside reset");

  dsb_order_a: assert property ( // R19
    @(posedge clk_sys_i) disable iff (srst_i)
    dsb_done_o |-> !(held_ppb && state != sam_pkg::ST_IDLE))
    else $error("data barrier done with control access pending");

  tick_off_a: assert property ( // R21
    @(posedge clk_sys_i) disable iff (srst_i)
    !tick_timer_enable_i && !tick_pend_set_o |=> !tick_pend_set_o)
    else $error("tick pend set with timer disabled");

  bg_region_a: assert property ( // R22
    @(posedge clk_sys_i) disable iff (srst_i)
    accept && protection_unit_enable_i && !protection_unit_hit_i &&
      !req_priv_i |=> hard_fault_exception_o)
    else $error("unprivileged background access allowed");

endmodule
`default_nettype wire

// File: sam_pkg.sv
// Function
// [R1] Top three address bits pick one of eight equal 0.5GB partitions.
// [R2] Lowest partition is code: Normal, executable, write-through.
// [R3] Second partition is RAM: Normal, executable, write-back allocate.
// [R4] Third partition is peripheral Device space, execute-never, uncached.
// [R5] Fourth partition is executable Normal memory, write-back allocate.
// [R6] Fifth partition is executable Normal memory, write-through.
// [R7] Sixth: shareable Device; seventh: unshared Device; both execute-never.
// [R8] Top partition is the execute-never system segment.
// [R9] First 1MB of system segment is private peripheral, rest vendor system.
// [R10] Software should put vendor resources high, leaving the gap reserved.
// [R11] Fetch from an execute-never region raises a hard fault.
// [R12] Declared cache policy may be demoted downstream but never upgraded.
// [R13] Strongly-ordered regions are always reported shareable.
// [R14] Exception vector table base is fixed at address zero.
// [R15] Data endianness is selectable, sampled from a strap at reset.
// [R16] Endianness affects data only; fetches are always little endian.
// [R17] Private peripheral loads and stores are always little endian.
// [R18] Selected endianness is readable as a status bit.
// [R19] Data barrier waits for pending system control accesses to finish.
// [R20] Instruction barrier completes only after every access has finished.
// [R21] Disabled tick timer never pends; pend clear stops later activation.
// [R22] Protection on: default map is privileged background only if enabled.
// [R23] Misaligned loads and stores raise a hard fault instead of accessing.
// [R24] Big endian data is byte-reversed across the 1, 2 or 4 byte size.
// [R25] Region attributes come combinationally in the request cycle.
// [R26] Private peripheral accesses go out as strongly-ordered, non-buffered.
package sam_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int PART_HI = 31;
  localparam int PART_LO = 29;
  localparam int SUB_HI = 28;
  localparam int SUB_LO = 20;
  localparam logic [2:0] PART_CODE = 3'h0;
  localparam logic [2:0] PART_SRAM = 3'h1;
  localparam logic [2:0] PART_PERIPH = 3'h2;
  localparam logic [2:0] PART_RAM_WRITE_BACK_ALLOCATE_POLICY = 3'h3;
  localparam logic [2:0] PART_RAM_WT = 3'h4;
  localparam logic [2:0] PART_DEV_SHARED = 3'h5;
  localparam logic [2:0] PART_DEV_PRIVATE = 3'h6;
  localparam logic [2:0] PART_SYSTEM = 3'h7;
  localparam logic [8:0] SUB_PRIVATE = 9'h000;
  localparam logic [31:0] VECTOR_BASE = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Attribute encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MEM_NORMAL = 2'b00,
    MEM_DEVICE = 2'b01,
    MEM_STRONG = 2'b10
  } sam_mem_type_t;

  typedef enum logic [1:0] {
    CACHE_NONE = 2'b00,
    CACHE_WRITE_BACK_ALLOCATE_POLICY = 2'b01,
    CACHE_WT = 2'b10
  } sam_cache_t;

  // ----------------------------------------------------------------
  // Access sizes
  // ----------------------------------------------------------------
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] LOW2_ZERO = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT = 2'b10
  } sam_state_t;

endpackage

// File: sam_byte_rev.sv
`timescale 1ns/1ps
`default_nettype none
module sam_byte_rev
(
  // Control
  input wire logic swap_i,
  input wire logic [1:0] size_i,
  // Data
  input wire logic [31:0] data_i,
  output logic [31:0] data_o
);

  // ----------------------------------------------------------------
  // Reversal across the access size
  // ----------------------------------------------------------------
  always_comb
  begin
    data_o = data_i;
    if (swap_i) // R24
    begin
      if (size_i == sam_pkg::SIZE_HALF)
      begin
        data_o = {16'h0000, data_i[7:0], data_i[15:8]};
      end
      else if (size_i == sam_pkg::SIZE_WORD)
      begin
        data_o = {data_i[7:0], data_i[15:8], data_i[23:16], data_i[31:24]};
      end
    end
  end

endmodule
`default_nettype wire

// File: sam_fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Memory fabric stand-in
// ----------------------------------------------------------------
module sam_fabric_model
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Fabric request
  input wire logic mem_req_i,
  input wire logic [3:0] delay_i,
  input wire logic [31:0] rd_val_i,
  output logic mem_done_o,
  output logic [31:0] mem_rdata_o
);
  logic [3:0] cnt;
  logic busy;
  // Read data is valid only with done; otherwise the bus shows the inverse.
  assign mem_rdata_o = mem_done_o ? rd_val_i : ~rd_val_i;
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      busy <= 1'b0;
      cnt <= 4'h0;
      mem_done_o <= 1'b0;
    end
    else
    begin
      mem_done_o <= 1'b0;
      if (mem_req_i)
      begin
        busy <= 1'b1;
        cnt <= delay_i;
      end
      else if (busy)
      begin
        if (cnt == 4'h0)
        begin
          busy <= 1'b0;
          mem_done_o <= 1'b1;
        end
        else
          cnt <= cnt - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: sam_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------
module sam_decode_tb;
  logic clk_sys_i, srst_i, strap, valid, wr, fetch, priv, pu_en, pdme, hit;
  logic data_sync_barrier, instr_sync_barrier, tk_en, tk_ev, tk_clr, ready, share, xn, private_peripheral_region, vend, dmap;
  logic fault, mreq, mwr, so, mdone, rvalid, endian, dsb_done, isb_done;
  logic pend, flt, gotreq;
  logic [31:0] addr, wdata, maddr, mwdata, mrdata, rdata, vbase, rd_val, a, d;
  logic [1:0] size, mtype, cache, msize;
  logic [3:0] delay, lat;
  logic [7:0] e;
  logic [31:0] corner [8];
  int fail_count, checked, dummy;
  time t_dsb, t_isb, t_end;

  sam_decode u_sam_decode
  (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .endian_strap_i(strap),
    .req_valid_i(valid), .req_addr_i(addr), .req_size_i(size),
    .req_write_i(wr), .req_fetch_i(fetch), .req_priv_i(priv),
    .req_wdata_i(wdata), .req_ready_o(ready), .attr_mem_type_o(mtype),
    .attr_cache_o(cache), .attr_shareable_o(share),
    .attr_execute_never_o(xn), .private_peripheral_region_o(private_peripheral_region),
    .vendor_system_region_o(vend), .default_map_used_o(dmap),
    .protection_unit_enable_i(pu_en),
    .privileged_default_map_enable_i(pdme), .protection_unit_hit_i(hit),
    .hard_fault_exception_o(fault), .mem_req_o(mreq), .mem_addr_o(maddr),
    .mem_size_o(msize), .mem_write_o(mwr), .mem_wdata_o(mwdata),
    .mem_strongly_ordered_o(so), .mem_done_i(mdone), .mem_rdata_i(mrdata),
    .rdata_o(rdata), .rvalid_o(rvalid), .endian_select_bit_o(endian),
    .vector_table_base_o(vbase), .data_sync_barrier_i(data_sync_barrier),
    .instr_sync_barrier_i(instr_sync_barrier), .dsb_done_o(dsb_done),
    .isb_done_o(isb_done), .tick_timer_enable_i(tk_en),
    .tick_event_i(tk_ev), .tick_pend_clear_i(tk_clr),
    .tick_pend_set_o(pend)
  );

  sam_fabric_model u_sam_fabric_model
  (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .mem_req_i(mreq),
    .delay_i(delay), .rd_val_i(rd_val), .mem_done_o(mdone),
    .mem_rdata_o(mrdata)
  );

  initial
  begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk_data(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x)
    begin
      fail_count++;
      $display("BAD t=%0t got %h expected %h", $time, g, x);
    end
  endtask

  task automatic chk_bit(input logic g, input logic x);
    checked++;
    if (g !== x)
    begin
      fail_count++;
      $display("BAD t=%0t flag %b expected %b", $time, g, x);
    end
  endtask

  // Packs {type, cache, shareable, execute_never, private, vendor}.
  function automatic logic [7:0] exp_attr(input logic [31:0] ad);
    case (ad[31:29])
      3'h0, 3'h4: return {sam_pkg::MEM_NORMAL, sam_pkg::CACHE_WT, 4'h0};
      3'h1, 3'h3: return {sam_pkg::MEM_NORMAL, sam_pkg::CACHE_WRITE_BACK_ALLOCATE_POLICY, 4'h0};
      3'h5: return {sam_pkg::MEM_DEVICE, sam_pkg::CACHE_NONE, 4'hC};
      3'h7:
        if (ad[28:20] == 9'h000)
          return {sam_pkg::MEM_STRONG, sam_pkg::CACHE_NONE, 4'hE};
        else
          return {sam_pkg::MEM_DEVICE, sam_pkg::CACHE_NONE, 4'h5};
      default: return {sam_pkg::MEM_DEVICE, sam_pkg::CACHE_NONE, 4'h4};
    endcase
  endfunction

  function automatic logic [31:0] exp_swap(input logic [31:0] v,
                                           input logic [1:0] s);
    case (s)
      sam_pkg::SIZE_HALF: return {16'h0000, v[7:0], v[15:8]};
      sam_pkg::SIZE_WORD: return {v[7:0], v[15:8], v[23:16], v[31:24]};
      default: return v;
    endcase
  endfunction

  // The strap flips after reset so a late sample would show.
  task automatic reset_dut(input logic st);
    @(posedge clk_sys_i);
    srst_i <= 1'b1;
    strap <= st;
    repeat (5) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    strap <= ~st;
  endtask

  task automatic access(input logic [31:0] ad, input logic [1:0] s,
                        input logic w, f, p, input logic [31:0] wd);
    @(posedge clk_sys_i);
    addr <= ad;
    size <= s;
    wr <= w;
    fetch <= f;
    priv <= p;
    wdata <= wd;
    delay <= lat;
    rd_val <= $urandom;
    valid <= 1'b1;
    @(posedge clk_sys_i);
    valid <= 1'b0;
    @(negedge clk_sys_i);
    flt = fault;
    gotreq = mreq;
    for (int n = 0; n < 40 && ready !== 1'b1; n++)
      @(negedge clk_sys_i);
    chk_bit(ready, 1'b1);
    if (gotreq === 1'b1 && w === 1'b0)
      chk_bit(rvalid, 1'b1);
  endtask

  initial
  begin
    dummy = $urandom(6798);
    {srst_i, strap, valid, wr, fetch, priv, pu_en, pdme, hit} = 9'h100;
    {data_sync_barrier, instr_sync_barrier, tk_en, tk_ev, tk_clr} = 5'h00;
    {addr, wdata, rd_val, size, delay, lat} = '0;
    corner = '{32'h1FFF_FFFF, 32'h2000_0000, 32'hDFFF_FFFF, 32'hE000_0000,
               32'hE00F_FFFF, 32'hE010_0000, 32'hF000_0000, 32'hFFFF_FFFF};
    reset_dut(1'b0);
    for (int i = 0; i < 72; i++)
    begin
      a = (i < 64) ? {3'(i), 29'($urandom)} : corner[i - 64];
      @(posedge clk_sys_i);
      addr <= a;
      @(negedge clk_sys_i);
      e = exp_attr(a);
      chk_data({30'h0, mtype}, {30'h0, e[7:6]});
      chk_data({30'h0, cache}, {30'h0, e[5:4]});
      chk_data({28'h0, share, xn, private_peripheral_region, vend}, {28'h0, e[3:0]});
    end
    chk_data(vbase, 32'h0000_0000);
    $display("test attributes done");
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk_sys_i);
      {pu_en, pdme, hit, priv} <= 4'(i);
      @(negedge clk_sys_i);
      chk_bit(dmap, !pu_en | (!hit & priv & pdme));
    end
    @(posedge clk_sys_i);
    {pdme, hit} <= 2'b00;
    access(32'h2000_0010, sam_pkg::SIZE_WORD, 1'b0, 1'b0, 1'b1, 32'h0);
    chk_bit(flt, 1'b1);
    @(posedge clk_sys_i);
    pdme <= 1'b1;
    access(32'h2000_0010, sam_pkg::SIZE_WORD, 1'b0, 1'b0, 1'b1, 32'h0);
    chk_bit(flt, 1'b0);
    access(32'h2000_0010, sam_pkg::SIZE_WORD, 1'b0, 1'b0, 1'b0, 32'h0);
    chk_bit(flt, 1'b1);
    @(posedge clk_sys_i);
    pu_en <= 1'b0;
    $display("test protection done");
    for (int p = 0; p < 8; p++)
    begin
      a = {3'(p), 29'h0000_0100};
      e = exp_attr(a);
      lat = 4'($urandom_range(3));
      access(a, sam_pkg::SIZE_WORD, 1'b0, 1'b1, 1'b1, 32'h0);
      chk_bit(flt, e[2]);
      chk_bit(gotreq, !e[2]);
    end
    for (int i = 0; i < 6; i++)
    begin
      access(32'h2000_0000 + ((i < 3) ? 1 : 3), 2'(i % 3 + 1), 1'(i), 1'b0,
             1'b1, $urandom);
      chk_bit(flt, 1'b1);
      chk_bit(gotreq, 1'b0);
    end
    $display("test faults done");
    chk_bit(endian, 1'b0);
    reset_dut(1'b1);
    chk_bit(endian, 1'b1);
    for (int s = 0; s < 3; s++)
    begin
      d = $urandom & ((s == 0) ? 32'hFF : (s == 1) ? 32'hFFFF : 32'hFFFFFFFF);
      lat = 4'($urandom_range(3));
      access(32'h2000_0040, 2'(s), 1'b1, 1'b0, 1'b1, d);
      chk_data(mwdata, exp_swap(d, 2'(s)));
    end
    d = $urandom;
    access(32'hE000_E010, sam_pkg::SIZE_WORD, 1'b1, 1'b0, 1'b1, d);
    chk_data(mwdata, d);
    chk_bit(so, 1'b1);
    chk_data(maddr, 32'hE000_E010);
    chk_bit(mwr, 1'b1);
    chk_data({30'h0, msize}, {30'h0, sam_pkg::SIZE_WORD});
    access(32'h6000_0080, sam_pkg::SIZE_WORD, 1'b0, 1'b0, 1'b1, 32'h0);
    chk_data(rdata, exp_swap(rd_val, sam_pkg::SIZE_WORD));
    access(32'h0000_0080, sam_pkg::SIZE_WORD, 1'b0, 1'b1, 1'b1, 32'h0);
    chk_data(rdata, rd_val);
    access(32'hE000_E000, sam_pkg::SIZE_WORD, 1'b0, 1'b0, 1'b1, 32'h0);
    chk_data(rdata, rd_val);
    reset_dut(1'b0);
    $display("test endian done");
    lat = 4'h8;
    t_dsb = 0;
    t_isb = 0;
    fork
      begin
        access(32'hE000_E010, sam_pkg::SIZE_WORD, 1'b1, 1'b0, 1'b1, 32'h1);
        t_end = $time;
      end
      begin
        repeat (3) @(posedge clk_sys_i);
        {data_sync_barrier, instr_sync_barrier} <= 2'b11;
        @(posedge clk_sys_i);
        {data_sync_barrier, instr_sync_barrier} <= 2'b00;
        for (int n = 0; n < 30 && (t_dsb == 0 || t_isb == 0); n++)
        begin
          @(negedge clk_sys_i);
          if (dsb_done === 1'b1 && t_dsb == 0)
            t_dsb = $time;
          if (isb_done === 1'b1 && t_isb == 0)
            t_isb = $time;
        end
      end
    join
    chk_bit(t_dsb != 0 && t_dsb + 50 >= t_end, 1'b1);
    chk_bit(t_isb != 0 && t_isb + 50 >= t_end, 1'b1);
    @(posedge clk_sys_i);
    {data_sync_barrier, instr_sync_barrier} <= 2'b11;
    @(posedge clk_sys_i);
    {data_sync_barrier, instr_sync_barrier} <= 2'b00;
    @(negedge clk_sys_i);
    chk_bit(dsb_done & isb_done, 1'b1);
    @(negedge clk_sys_i);
    chk_bit(dsb_done | isb_done, 1'b0);
    $display("test barriers done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys_i);
      tk_en <= (i == 1 || i == 2);
      tk_ev <= (i != 2);
      tk_clr <= (i == 2);
      @(posedge clk_sys_i);
      {tk_ev, tk_clr} <= 2'b00;
      @(negedge clk_sys_i);
      chk_bit(pend, i == 1);
    end
    $display("test tick done");
    summarize();
  end

  initial
  begin
    #500us;
    fail_count++;
    $display("BAD t=%0t watchdog expired", $time);
    summarize();
  end

  task automatic summarize();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
endmodule
`default_nettype wire
